/* hdl/mrsp_pkg.sv */
// constants for the midi running status parser
// ============================================================
// How it works
// - status bytes have bit 7 set, data bytes clear; one status opens each message
// - status 0x80 to 0xEF is a channel message, low nybble picks the channel
// - channel messages carry one or two data bytes, never zero or more
// - status 0xF0 to 0xFF is system; bit 3 splits common/real-time, low nybble is type
// - sysex opens at 0xF0 and runs over data bytes until 0xF7
// - data bytes with no held status are dropped; next status resynchronises
// - each channel status becomes the held running status for later data bytes
// - system common status 0xF0 to 0xF7 clears the held running status
// - real-time status 0xF8 to 0xFF keeps running status and has no data
// - real-time bytes inside a channel message keep the partial message intact
// - note-on with zero velocity acts as note-off for that note
// - message packet: byte1 code index and cable, byte2 status, bytes3-4 data
// - the cable number is ignored; all cables share sixteen channels
// - single-byte code index feeds its byte into the stream parser
// - sysex content is not interpreted; multi-packet sysex is passed over
// - two entries: whole message path and single raw byte path
// - on the byte path a status with upper nybble 0xF goes to the message path
// - every system message acts on its status byte alone; system data bytes ignored
// - two-byte buffer, low first data, high second; 0xFF marks a missing byte
// - channel status loads buffer 0x00FF for one data byte, 0xFFFF for two
// - data goes low if buffer bit 7 set, else high; done when bit 15 clear
// - after dispatch buffer reloads for same count so running data makes new messages
// - 0xF8 fires timing clock, 0xFA fires tempo start
package mrsp_pkg;
    localparam logic [7:0]  STAT_SYS_CLK   = 8'hF8;
    localparam logic [7:0]  STAT_SYS_START = 8'hFA;
    localparam logic [7:0]  STAT_SYSEX     = 8'hF0;
    localparam logic [7:0]  STAT_SYSEX_END = 8'hF7;
    localparam logic [3:0]  NYB_SYSTEM     = 4'hF;
    localparam logic [2:0]  TYPE_NOTE_OFF  = 3'h0;
    localparam logic [2:0]  TYPE_NOTE_ON   = 3'h1;
    localparam logic [2:0]  TYPE_PROG      = 3'h4;
    localparam logic [2:0]  TYPE_CHPRESS   = 3'h5;
    localparam logic [15:0] BUF_ONE        = 16'h00FF;
    localparam logic [15:0] BUF_TWO        = 16'hFFFF;
    localparam logic [7:0]  BYTE_EMPTY     = 8'hFF;
    localparam logic [3:0]  CIN_SINGLE     = 4'hF;
    localparam logic [7:0]  STAT_NONE      = 8'h00;
endpackage : mrsp_pkg

/* hdl/mrsp_parser.sv */
// midi running status parser: packet and byte entries, message dispatch
`timescale 1ns/1ps
module mrsp_parser
    import mrsp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // whole message entry
    input  wire logic        msgValid,
    input  wire logic [7:0]  msgStatus,
    input  wire logic [15:0] msgData,
    // raw byte entry
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteIn,
    // usb-midi packet entry
    input  wire logic        pktValid,
    input  wire logic [31:0] pktWord,
    // dispatched message
    output logic             outValid,
    output logic [7:0]       outStatus,
    output logic [3:0]       outChannel,
    output logic [6:0]       outData1,
    output logic [6:0]       outData2,
    output logic             outNoteOff,
    output logic             outNoteOn,
    output logic             outSystem,
    output logic             outRealTime,
    output logic [3:0]       outSysType,
    // tempo strobes and state
    output logic             timingClock,
    output logic             timingStart,
    output logic [7:0]       runStatus,
    output logic             sysexActive
);
    // ============================================================
    // entry selection
    logic        pktMsg;
    logic        pktByte;
    logic        inMsg;
    logic        inByte;
    logic [7:0]  mStatus;
    logic [15:0] mData;
    logic [7:0]  bVal;

    // cable nybble pktWord[7:4] is never looked at
    // cable dropped
    assign pktMsg  = pktValid && (pktWord[3:0] != CIN_SINGLE);
    assign pktByte = pktValid && (pktWord[3:0] == CIN_SINGLE);
    // two entries; direct byte path wins over a single-byte packet when both fire, a message packet wins over the byte path
    assign inByte  = byteValid || pktByte;
    assign bVal    = byteValid ? byteIn : pktWord[15:8];

    // ============================================================
    // state
    logic [7:0]  runStatus_r;
    logic [7:0]  runStatus_nxt;
    logic [15:0] buf_r;
    logic [15:0] buf_nxt;
    logic        sysex_r;
    logic        sysex_nxt;
    logic        fire;
    logic [7:0]  fStatus;
    logic [15:0] fData;

    function automatic logic [15:0] bufInit(input logic [7:0] st);
        if (st[6:4] == TYPE_PROG || st[6:4] == TYPE_CHPRESS)
            bufInit = BUF_ONE;
        else
            bufInit = BUF_TWO;
    endfunction : bufInit

    // byte stream parsing, next state
    always_comb
    begin
        runStatus_nxt = runStatus_r;
        buf_nxt       = buf_r;
        sysex_nxt     = sysex_r;
        fire          = 1'b0;
        fStatus       = STAT_NONE;
        fData         = 16'h0000;
        inMsg         = 1'b0;
        mStatus       = STAT_NONE;
        mData         = 16'h0000;
        if (msgValid || pktMsg)
        begin
            inMsg   = 1'b1;
            mStatus = msgValid ? msgStatus : pktWord[15:8];
            mData   = msgValid ? msgData : pktWord[31:16];
        end
        else if (inByte)
        begin
            // bit 7 splits status and data
            if (bVal[7])
            begin
                if (bVal[7:4] == NYB_SYSTEM)
                begin
                    inMsg   = 1'b1;
                    mStatus = bVal;
                end
                else
                begin
                    runStatus_nxt = bVal;
                    buf_nxt = bufInit(bVal);
                end
            end
            else if (runStatus_r != STAT_NONE)
            begin
                if (buf_r[7])
                    buf_nxt[7:0] = bVal;
                else
                    buf_nxt[15:8] = bVal;
                if (!buf_nxt[15])
                begin
                    fire    = 1'b1;
                    fStatus = runStatus_r;
                    fData   = buf_nxt;
                    buf_nxt = bufInit(runStatus_r);
                end
            end
        end
        // system status effects on held state; message path channel status is stored too
        if (inMsg && mStatus[7])
        begin
            if (mStatus[7:4] != NYB_SYSTEM)
            begin
                runStatus_nxt = mStatus;
                buf_nxt       = bufInit(mStatus);
            end
            else if (!mStatus[3])
            begin
                runStatus_nxt = STAT_NONE;
                sysex_nxt = (mStatus == STAT_SYSEX);
            end
        end
        if (inMsg && mStatus[7])
        begin
            fire    = 1'b1;
            fStatus = mStatus;
            fData   = mData;
        end
    end

    // ============================================================
    // output decode
    logic        oValid_nxt;
    logic        oNoteOn_nxt;
    logic        oNoteOff_nxt;
    logic        oSys_nxt;
    logic        oRt_nxt;
    logic        tClk_nxt;
    logic        tStart_nxt;
    logic [15:0] cleanData;

    always_comb
    begin
        cleanData    = {1'b0, fData[14:8], 1'b0, fData[6:0]};
        oSys_nxt     = fire && (fStatus[7:4] == NYB_SYSTEM);
        // bit 3 splits the system kinds
        oRt_nxt      = oSys_nxt && fStatus[3];
        oValid_nxt   = fire;
        oNoteOff_nxt = fire && !oSys_nxt && ((fStatus[6:4] == TYPE_NOTE_OFF)
                       || (fStatus[6:4] == TYPE_NOTE_ON && cleanData[14:8] == 7'h00));
        oNoteOn_nxt  = fire && !oSys_nxt && (fStatus[6:4] == TYPE_NOTE_ON)
                       && (cleanData[14:8] != 7'h00);
        tClk_nxt     = fire && (fStatus == STAT_SYS_CLK);
        tStart_nxt   = fire && (fStatus == STAT_SYS_START);
        // system data dropped on the output
        if (oSys_nxt)
            cleanData = 16'h0000;
        // one-byte types report no second byte
        else if (bufInit(fStatus) == BUF_ONE)
            cleanData[15:8] = 8'h00;
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            runStatus_r <= STAT_NONE;
            buf_r       <= BUF_TWO;
            sysex_r     <= 1'b0;
            outValid    <= 1'b0;
            outStatus   <= 8'h00;
            outChannel  <= 4'h0;
            outData1    <= 7'h00;
            outData2    <= 7'h00;
            outNoteOff  <= 1'b0;
            outNoteOn   <= 1'b0;
            outSystem   <= 1'b0;
            outRealTime <= 1'b0;
            outSysType  <= 4'h0;
            timingClock <= 1'b0;
            timingStart <= 1'b0;
        end
        else
        begin
            runStatus_r <= runStatus_nxt;
            buf_r       <= buf_nxt;
            sysex_r     <= sysex_nxt;
            outValid    <= oValid_nxt;
            outStatus   <= fire ? fStatus : outStatus;
            outChannel  <= (fire && !oSys_nxt) ? fStatus[3:0] : outChannel;
            outData1    <= fire ? cleanData[6:0] : outData1;
            outData2    <= fire ? cleanData[14:8] : outData2;
            outNoteOff  <= oNoteOff_nxt;
            outNoteOn   <= oNoteOn_nxt;
            outSystem   <= oSys_nxt;
            outRealTime <= oRt_nxt;
            outSysType  <= oSys_nxt ? fStatus[3:0] : outSysType;
            timingClock <= tClk_nxt;
            timingStart <= tStart_nxt;
        end
    end

    assign runStatus   = runStatus_r;
    assign sysexActive = sysex_r;

    // ============================================================
    // checks
    // byte path antecedents exclude the message path, which wins the cycle
    // common clears held status
    AST_COMMON_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && bVal[7:3] == 5'h1E) |=> runStatus == 8'h00)
        else $error("system common left running status");
    AST_RT_KEEPS: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && bVal[7:3] == 5'h1F) |=> $stable(runStatus))
        else $error("real-time changed running status");
    AST_RT_BUF: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && bVal[7:3] == 5'h1F) |=> $stable(buf_r))
        else $error("real-time disturbed partial message");
    AST_SYSEX_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && bVal == 8'hF0) |=> sysexActive)
        else $error("sysex start not tracked");
    AST_CHAN_HELD: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && bVal[7] && bVal[7:4] != 4'hF)
        |=> runStatus == $past(bVal))
        else $error("channel status not held");
    AST_DROP_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && !bVal[7] && runStatus == 8'h00)
        |=> !outValid && $stable(buf_r))
        else $error("orphan data byte used");
    AST_STATUS_BIT: assert property (@(posedge clk) disable iff (!rst_n)
        (msgValid && !msgStatus[7]) |=> !outValid)
        else $error("message without status bit dispatched");
    AST_CLK_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
        timingClock |-> outValid && outStatus == 8'hF8 && outRealTime)
        else $error("timing clock without 0xF8");
    AST_START_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
        timingStart |-> outStatus == 8'hFA && outSystem)
        else $error("start strobe without 0xFA");
    AST_ZERO_VEL: assert property (@(posedge clk) disable iff (!rst_n)
        (outValid && !outSystem && outStatus[6:4] == 3'h1 && outData2 == 7'h00)
        |-> outNoteOff && !outNoteOn)
        else $error("zero velocity note-on not note-off");
    AST_CHANNEL: assert property (@(posedge clk) disable iff (!rst_n)
        (outValid && !outSystem) |-> outChannel == outStatus[3:0])
        else $error("channel not taken from status");
    AST_ONE_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
        (outValid && !outSystem && outStatus[6:5] == 2'h2) |-> outData2 == 7'h00)
        else $error("second data byte on one-byte message");
    AST_SYS_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        outSystem |-> outData1 == 7'h00 && outData2 == 7'h00)
        else $error("system message carried data");
    AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && !bVal[7] && runStatus != 8'h00 && !buf_nxt[15])
        |=> outValid && buf_r == ((runStatus[6:5] == 2'h2) ? 16'h00FF : 16'hFFFF))
        else $error("buffer not reloaded after message");
    AST_PRELOAD_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        (inByte && !msgValid && !pktMsg && bVal[7:4] == 4'hC) |=> buf_r == 16'h00FF)
        else $error("program change preload wrong");
endmodule : mrsp_parser

/* verification/mrsp_usb_source.sv */
// usb-midi packet source model for the running status parser bench
`timescale 1ns/1ps
module mrsp_usb_source
    import mrsp_pkg::*;
(
    // clock
    input  wire logic        clk,
    // packet out
    output logic             pktValid,
    output logic [31:0]      pktWord
);
    // ============================================================
    // idle state at time zero
    initial
    begin
        pktValid = 1'b0;
        pktWord  = 32'h0000_0000;
    end

    // one packet per call, one cycle long; callers pass a status or a data byte in b1
    task automatic send(input logic [3:0] cin, input logic [3:0] cable,
                        input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        @(posedge clk);
        pktValid <= 1'b1;
        pktWord  <= {b3, b2, b1, cable, cin};
        @(posedge clk);
        pktValid <= 1'b0;
        // stale word is inverted so a late sampler never sees a good packet
        pktWord  <= ~{b3, b2, b1, cable, cin};
    endtask : send
endmodule : mrsp_usb_source

/* verification/tb_midi_running_status_parser.sv */
// self-checking bench for the midi running status parser
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        checkCount++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module tb_midi_running_status_parser;
    import mrsp_pkg::*;
    typedef struct packed {
        logic [7:0] b;
        logic       v;
        logic       on;
        logic       off;
        logic [6:0] d1;
        logic [6:0] d2;
        logic [1:0] tmp;
        logic [7:0] run;
    } mrsp_row_t;
    logic        clk = 1'b0, rst_n = 1'b0, msgValid = 1'b0, byteValid = 1'b0;
    logic [7:0]  msgStatus = 8'h00, byteIn = 8'h00, outStatus, runStatus;
    logic [15:0] msgData = 16'h0000;
    logic        pktValid, outValid, outNoteOff, outNoteOn, outSystem, outRealTime;
    logic        timingClock, timingStart, sysexActive;
    logic [31:0] pktWord;
    logic [3:0]  outChannel, outSysType;
    logic [6:0]  outData1, outData2;
    int          errors = 0, checkCount = 0;
    // byte stream with expected dispatch: byte, valid/on/off, data1, data2, tempo, run
    mrsp_row_t   rows [21] = '{
        {8'h3C,3'b000,7'h00,7'h00,2'b00,8'h00}, {8'h90,3'b000,7'h00,7'h00,2'b00,8'h90},
        {8'h3C,3'b000,7'h00,7'h00,2'b00,8'h90}, {8'hF8,3'b000,7'h00,7'h00,2'b10,8'h90},
        {8'h40,3'b110,7'h3C,7'h40,2'b00,8'h90}, {8'h3C,3'b000,7'h00,7'h00,2'b00,8'h90},
        {8'h00,3'b101,7'h3C,7'h00,2'b00,8'h90}, {8'hC5,3'b000,7'h00,7'h00,2'b00,8'hC5},
        {8'h07,3'b100,7'h07,7'h00,2'b00,8'hC5}, {8'h08,3'b100,7'h08,7'h00,2'b00,8'hC5},
        {8'hF6,3'b000,7'h00,7'h00,2'b00,8'h00}, {8'h11,3'b000,7'h00,7'h00,2'b00,8'h00},
        {8'hE2,3'b000,7'h00,7'h00,2'b00,8'hE2}, {8'h01,3'b000,7'h00,7'h00,2'b00,8'hE2},
        {8'hFA,3'b000,7'h00,7'h00,2'b01,8'hE2}, {8'h7F,3'b100,7'h01,7'h7F,2'b00,8'hE2},
        {8'hD3,3'b000,7'h00,7'h00,2'b00,8'hD3}, {8'h55,3'b100,7'h55,7'h00,2'b00,8'hD3},
        {8'hF0,3'b000,7'h00,7'h00,2'b00,8'h00}, {8'h22,3'b000,7'h00,7'h00,2'b00,8'h00},
        {8'hF7,3'b000,7'h00,7'h00,2'b00,8'h00}};

    // ============================================================
    // clock, watchdog and instances
    always #20 clk = ~clk;
    // a hang is cut short after 20000 cycles, far beyond what the test needs
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end
    mrsp_usb_source i_mrsp_usb_source (.clk(clk), .pktValid(pktValid), .pktWord(pktWord));
    mrsp_parser i_mrsp_parser (.clk(clk), .rst_n(rst_n), .msgValid(msgValid),
        .msgStatus(msgStatus), .msgData(msgData), .byteValid(byteValid), .byteIn(byteIn),
        .pktValid(pktValid), .pktWord(pktWord), .outValid(outValid), .outStatus(outStatus),
        .outChannel(outChannel), .outData1(outData1), .outData2(outData2),
        .outNoteOff(outNoteOff), .outNoteOn(outNoteOn), .outSystem(outSystem),
        .outRealTime(outRealTime), .outSysType(outSysType), .timingClock(timingClock),
        .timingStart(timingStart), .runStatus(runStatus), .sysexActive(sysexActive));

    // ============================================================
    // drivers: request for one cycle, then look at the settled answer
    task automatic sendByte(input logic [7:0] b);
        @(posedge clk);
        byteValid <= 1'b1;
        byteIn    <= b;
        @(posedge clk);
        byteValid <= 1'b0;
        @(negedge clk);
    endtask : sendByte
    task automatic sendMsg(input logic [7:0] s, input logic [15:0] d);
        @(posedge clk);
        msgValid  <= 1'b1;
        msgStatus <= s;
        msgData   <= d;
        @(posedge clk);
        msgValid  <= 1'b0;
        @(negedge clk);
    endtask : sendMsg
    task automatic sendPkt(input logic [3:0] cin, input logic [3:0] cab,
                           input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        i_mrsp_usb_source.send(cin, cab, b1, b2, b3);
        @(negedge clk);
    endtask : sendPkt
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // ============================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("resetRun", 8'h00, runStatus)
        `CHK("resetFlags", 3'b000, {outValid, sysexActive, timingClock})
        $display("reset test done");
        // byte path table, one row per byte
        foreach (rows[i])
        begin
            sendByte(rows[i].b);
            `CHK("outValid", rows[i].v, outValid & ~outSystem)
            `CHK("noteFlags", {rows[i].on, rows[i].off}, {outNoteOn, outNoteOff})
            if (rows[i].v)
                `CHK("data", {rows[i].d1, rows[i].d2}, {outData1, outData2})
            `CHK("tempo", rows[i].tmp, {timingClock, timingStart})
            `CHK("runStatus", rows[i].run, runStatus)
        end
        $display("table test done");
        // whole message entry, a bad status and a real-time message
        sendMsg(8'hB7, 16'h2A15);
        `CHK("msgOut", {1'b1, 8'hB7, 4'h7}, {outValid, outStatus, outChannel})
        `CHK("msgData", {7'h15, 7'h2A}, {outData1, outData2})
        sendMsg(8'h35, 16'h0000);
        `CHK("badStatus", 1'b0, outValid)
        sendMsg(8'hF8, 16'h0000);
        `CHK("realTime", {1'b1, 1'b1, 4'h8}, {timingClock, outRealTime, outSysType})
        $display("message test done");
        // sysex opens and closes; its content is passed over
        sendByte(8'hF0);
        `CHK("sysexOn", 1'b1, sysexActive)
        sendByte(8'h12);
        `CHK("sysexData", 1'b0, outValid)
        sendByte(8'hF7);
        `CHK("sysexOff", 1'b0, sysexActive)
        $display("sysex test done");
        // packet entry: whole message on a foreign cable, then single bytes
        sendPkt(4'h9, 4'hA, 8'h93, 8'h3C, 8'h00);
        `CHK("pktMsg", {1'b1, 1'b0, 4'h3}, {outNoteOff, outNoteOn, outChannel})
        sendPkt(CIN_SINGLE, 4'h5, 8'hA1, 8'h00, 8'h00);
        `CHK("pktRun", 8'hA1, runStatus)
        sendPkt(CIN_SINGLE, 4'h5, 8'h20, 8'h00, 8'h00);
        sendPkt(CIN_SINGLE, 4'h5, 8'h30, 8'h00, 8'h00);
        `CHK("pktOut", {1'b1, 8'hA1, 7'h20, 7'h30}, {outValid, outStatus, outData1, outData2})
        $display("packet test done");
        // reset in mid-message drops the held status
        sendByte(8'h90);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("midReset", {1'b0, 8'h00}, {outValid, runStatus})
        $display("mid reset test done");
        final_report();
    end
endmodule : tb_midi_running_status_parser
